// ===== design/sar_adc_sequence_control.sv
// sequence control of a four channel successive-approximation converter
`timescale 1ns/1ps
`include "sar_adc_sequence_control_cfg.svh"

module sar_adc_sequence_control (
    input  wire logic                                      ref_clk,
    input  wire logic                                      rst_b,
    input  wire sar_adc_sequence_control_pkg::apb_req_t    apbReq,
    output logic                                           pready,
    output logic [31:0]                                    prdata,
    output logic                                           pslverr,
    input  wire logic                                      rcTick,
    input  wire logic                                      extTrigger,
    input  wire logic                                      convDone,
    input  wire logic [9:0]                                convData,
    output sar_adc_sequence_control_pkg::analog_ctl_t      analogCtl,
    output logic                                           adcIntPulse,
    output logic                                           bufferHalf
);
    import sar_adc_sequence_control_pkg::*;

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    // next selected scan input above cur, wrapping; cur kept if none selected
    function automatic logic [2:0] next_scan(input logic [2:0] cur, input logic [5:0] sel);
        logic [2:0] res;
        logic       hit;
        logic [2:0] idx;
        res = cur;
        hit = 1'b0;
        for (int i = 1; i <= 6; i++) begin
            idx = 3'((32'(cur) + i) % 6);
            if (!hit && sel[idx]) begin
                res = idx;
                hit = 1'b1;
            end
        end
        return res;
    endfunction : next_scan

    function automatic logic [15:0] merge_write(input logic [15:0] old, input logic [31:0] wd,
                                                input logic [15:0] mask);
        return (old & ~mask) | (wd[15:0] & mask);
    endfunction : merge_write

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    seq_regs_t   st_ff;
    seq_regs_t   nxt_st;
    logic [9:0]  resultMem [16];
    logic [9:0]  memRead;
    logic        tadTick;
    logic        takeWrite;
    logic        setup;
    logic        trigger;
    logic [1:0]  lastChan;
    logic [3:0]  wrAddr;
    logic [15:0] rd16;
    logic [2:0]  scanCur;

    assign memRead = resultMem[apbReq.paddr[5:2]];

    always_comb begin
        nxt_st = st_ff;
        nxt_st.intPulse = 1'b0;
        nxt_st.bufWe = 1'b0;
        nxt_st.rsp.pready = 1'b1;
        nxt_st.ana.convStart = 1'b0;
        setup = apbReq.psel && !apbReq.penable;
        takeWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;
        rd16 = 16'h0000;

        // ---------------------------------------------------------------
        // conversion clock
        // ---------------------------------------------------------------
        // reserved divider codes are not trapped; they just run slower
        tadTick = 1'b0;
        if (st_ff.con3[`BIT_CLOCK_SOURCE]) begin
            tadTick = rcTick;
            nxt_st.divCnt = 8'h00;
        end else if (st_ff.divCnt >= st_ff.con3[7:0]) begin
            tadTick = 1'b1;
            nxt_st.divCnt = 8'h00;
        end else begin
            nxt_st.divCnt = st_ff.divCnt + 8'h01;
        end
        nxt_st.ana.rcClockSel = st_ff.con3[`BIT_CLOCK_SOURCE];
        nxt_st.ana.referenceConfig = st_ff.con2[15:13];

        // ---------------------------------------------------------------
        // register writes
        // ---------------------------------------------------------------
        if (takeWrite) begin
            unique case (apbReq.paddr)
                `OFS_CONTROL_TWO: begin
                    nxt_st.con2 = merge_write(st_ff.con2, apbReq.pwdata, `MASK_CONTROL_TWO);
                end
                `OFS_CONTROL_THREE: begin
                    nxt_st.con3 = merge_write(st_ff.con3, apbReq.pwdata, `MASK_CONTROL_THREE);
                end
                `OFS_CH123_SELECT: begin
                    nxt_st.chs123 = merge_write(st_ff.chs123, apbReq.pwdata, `MASK_CH123_SELECT);
                end
                `OFS_CH_ZERO_SELECT: begin
                    nxt_st.chs0 = merge_write(st_ff.chs0, apbReq.pwdata, `MASK_CH_ZERO_SELECT);
                end
                `OFS_RUN_CONTROL: begin
                    nxt_st.runCtl = merge_write(st_ff.runCtl, apbReq.pwdata, `MASK_RUN_CONTROL);
                end
                `OFS_SCAN_SELECT: begin
                    nxt_st.scanSel = apbReq.pwdata[5:0];
                end
                default: begin
                end
            endcase
        end

        // ---------------------------------------------------------------
        // sequencer
        // ---------------------------------------------------------------
        unique case (st_ff.con2[`BIT_CH_COUNT_HI:`BIT_CH_COUNT_LO])
            2'b00:   lastChan = 2'd0;
            2'b01:   lastChan = 2'd1;
            default: lastChan = 2'd3;
        endcase
        unique case (st_ff.runCtl[`BIT_TRIG_HI:`BIT_TRIG_LO])
            `TRIG_AUTO:   trigger = tadTick && st_ff.smpCnt == 5'd0;
            `TRIG_MANUAL: trigger = !st_ff.runCtl[`BIT_SAMPLE_REQ];
            default:      trigger = extTrigger;
        endcase
        wrAddr = st_ff.con2[`BIT_SPLIT_BUFFER] ? {st_ff.half, st_ff.wrPtr[2:0]} : st_ff.wrPtr;
        // sample an input not selected for the scan only when no input is selected at all
        scanCur = st_ff.scanSel[st_ff.scanIdx] ? st_ff.scanIdx : next_scan(st_ff.scanIdx, st_ff.scanSel);

        unique case (st_ff.seq)
            IDLE: begin
                if (st_ff.runCtl[`BIT_MODULE_ON]
                    && (st_ff.runCtl[`BIT_AUTO_SAMPLE] || st_ff.runCtl[`BIT_SAMPLE_REQ])) begin
                    nxt_st.seq = SAMPLE;
                    nxt_st.ana.sampling = 1'b1;
                    nxt_st.runCtl[`BIT_SAMPLE_REQ] = 1'b1;
                    nxt_st.smpCnt = st_ff.con3[`BIT_SAMPLE_HI:`BIT_SAMPLE_LO];
                    if (st_ff.useB) begin
                        nxt_st.ana.chZeroPos = st_ff.chs0[12:8];
                        nxt_st.ana.chZeroNegIn1 = st_ff.chs0[`BIT_NEG_B_ZERO];
                        nxt_st.ana.ch123PosHigh = st_ff.chs123[`BIT_POS_B_123];
                        nxt_st.ana.ch123NegGround = !st_ff.chs123[`BIT_NEG_B_HI];
                    end else begin
                        // scanning overrides the sample A code
                        nxt_st.ana.chZeroPos = st_ff.con2[`BIT_SCAN_ENABLE]
                                             ? {2'b00, scanCur}
                                             : st_ff.chs0[4:0];
                        if (st_ff.con2[`BIT_SCAN_ENABLE]) begin
                            nxt_st.scanIdx = scanCur;
                        end
                        nxt_st.ana.chZeroNegIn1 = st_ff.chs0[`BIT_NEG_A_ZERO];
                        nxt_st.ana.ch123PosHigh = st_ff.chs123[`BIT_POS_A_123];
                        nxt_st.ana.ch123NegGround = !st_ff.chs123[`BIT_NEG_A_HI];
                    end
                end
            end
            SAMPLE: begin
                // sample count only matters under the internal counter trigger
                if (tadTick && st_ff.smpCnt != 5'd0) begin
                    nxt_st.smpCnt = st_ff.smpCnt - 5'd1;
                end
                if (!st_ff.runCtl[`BIT_MODULE_ON]) begin
                    nxt_st.seq = IDLE;
                    nxt_st.ana.sampling = 1'b0;
                end else if (trigger) begin
                    nxt_st.seq = CONVERT;
                    nxt_st.ana.sampling = 1'b0;
                    nxt_st.runCtl[`BIT_SAMPLE_REQ] = 1'b0;
                    nxt_st.chanIdx = 2'd0;
                    nxt_st.ana.convStart = 1'b1;
                    nxt_st.ana.convChan = 2'd0;
                end
            end
            CONVERT: begin
                if (convDone) begin
                    nxt_st.bufWe = 1'b1;
                    nxt_st.bufAddr = wrAddr;
                    nxt_st.bufData = convData;
                    nxt_st.wrPtr = st_ff.wrPtr + 4'd1;
                    nxt_st.seq = STORE;
                end
            end
            STORE: begin
                // every stored channel result counts toward the interrupt
                if (st_ff.opCnt == st_ff.con2[`BIT_RATE_HI:`BIT_RATE_LO]) begin
                    nxt_st.intPulse = 1'b1;
                    nxt_st.opCnt = 4'd0;
                    nxt_st.wrPtr = 4'd0;
                    nxt_st.half = st_ff.con2[`BIT_SPLIT_BUFFER] && !st_ff.half;
                end else begin
                    nxt_st.opCnt = st_ff.opCnt + 4'd1;
                end
                if (st_ff.chanIdx != lastChan) begin
                    nxt_st.chanIdx = st_ff.chanIdx + 2'd1;
                    nxt_st.ana.convStart = 1'b1;
                    nxt_st.ana.convChan = st_ff.chanIdx + 2'd1;
                    nxt_st.seq = CONVERT;
                end else begin
                    nxt_st.seq = IDLE;
                    nxt_st.useB = st_ff.con2[`BIT_ALTERNATE_INPUT] && !st_ff.useB;
                    if (st_ff.con2[`BIT_SCAN_ENABLE] && !st_ff.useB) begin
                        nxt_st.scanIdx = next_scan(st_ff.scanIdx, st_ff.scanSel);
                    end
                end
            end
        endcase
        if (st_ff.con2[`BIT_SPLIT_BUFFER] && st_ff.wrPtr[2:0] == `SPLIT_HALF_WORDS && nxt_st.bufWe) begin
            nxt_st.wrPtr = 4'd0;
        end
        if (!st_ff.runCtl[`BIT_MODULE_ON]) begin
            nxt_st.opCnt = 4'd0;
        end

        // ---------------------------------------------------------------
        // register reads, answered with zero wait states
        // ---------------------------------------------------------------
        if (setup) begin
            nxt_st.rsp.pslverr = 1'b0;
            unique case (apbReq.paddr)
                `OFS_CONTROL_TWO: begin
                    rd16 = st_ff.con2 & `MASK_CONTROL_TWO;
                    rd16[`BIT_BUFFER_HALF] = st_ff.con2[`BIT_SPLIT_BUFFER] && st_ff.half;
                end
                `OFS_CONTROL_THREE:  rd16 = st_ff.con3 & `MASK_CONTROL_THREE;
                `OFS_CH123_SELECT:   rd16 = st_ff.chs123 & `MASK_CH123_SELECT;
                `OFS_CH_ZERO_SELECT: rd16 = st_ff.chs0 & `MASK_CH_ZERO_SELECT;
                `OFS_RUN_CONTROL:    rd16 = st_ff.runCtl & `MASK_RUN_CONTROL;
                `OFS_SCAN_SELECT:    rd16 = {10'h000, st_ff.scanSel};
                default: begin
                    if (apbReq.paddr[7:6] == 2'b01) begin
                        rd16 = {6'h00, memRead};
                    end else begin
                        nxt_st.rsp.pslverr = 1'b1;
                    end
                end
            endcase
            nxt_st.rsp.prdata = {16'h0000, rd16};
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // result buffer holds no reset; contents are unknown until written
    always_ff @(posedge ref_clk) begin
        if (st_ff.bufWe) begin
            resultMem[st_ff.bufAddr] <= st_ff.bufData;
        end
    end

    assign pready      = st_ff.rsp.pready;
    assign prdata      = st_ff.rsp.prdata;
    assign pslverr     = st_ff.rsp.pslverr;
    assign analogCtl   = st_ff.ana;
    assign adcIntPulse = st_ff.intPulse;
    assign bufferHalf  = st_ff.half;
endmodule : sar_adc_sequence_control

// ===== pkg/sar_adc_sequence_control_cfg.svh
// register map, field positions and reset values of the converter sequence control
`ifndef SAR_ADC_SEQUENCE_CONTROL_CFG_SVH
`define SAR_ADC_SEQUENCE_CONTROL_CFG_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_CONTROL_TWO    8'h00
`define OFS_CONTROL_THREE  8'h04
`define OFS_CH123_SELECT   8'h08
`define OFS_CH_ZERO_SELECT 8'h0c
`define OFS_RUN_CONTROL    8'h10
`define OFS_SCAN_SELECT    8'h14
`define OFS_RESULT_BASE    8'h40
// ---------------------------------------------------------------
// writable / readable masks, unimplemented bits read zero
// ---------------------------------------------------------------
`define MASK_CONTROL_TWO    16'he73f
`define MASK_CONTROL_THREE  16'h9fff
`define MASK_CH123_SELECT   16'h0707
`define MASK_CH_ZERO_SELECT 16'h9f9f
`define MASK_RUN_CONTROL    16'h00e7
`define MASK_SCAN_SELECT    16'h003f
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BIT_SCAN_ENABLE     10
`define BIT_CH_COUNT_HI     9
`define BIT_CH_COUNT_LO     8
`define BIT_BUFFER_HALF     7
`define BIT_RATE_HI         5
`define BIT_RATE_LO         2
`define BIT_SPLIT_BUFFER    1
`define BIT_ALTERNATE_INPUT 0
`define BIT_CLOCK_SOURCE    15
`define BIT_SAMPLE_HI       12
`define BIT_SAMPLE_LO       8
`define BIT_NEG_B_HI        10
`define BIT_POS_B_123       8
`define BIT_NEG_A_HI        2
`define BIT_POS_A_123       0
`define BIT_NEG_B_ZERO      15
`define BIT_NEG_A_ZERO      7
`define BIT_MODULE_ON       0
`define BIT_SAMPLE_REQ      1
`define BIT_AUTO_SAMPLE     2
`define BIT_TRIG_HI         7
`define BIT_TRIG_LO         5
// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define RESET_REG16      16'h0000
`define TRIG_MANUAL      3'h0
`define TRIG_AUTO        3'h7
`define SPLIT_HALF_WORDS 3'h7
`endif

// ===== pkg/sar_adc_sequence_control_pkg.sv
// types of the converter sequence control
package sar_adc_sequence_control_pkg;
    typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT, STORE} seq_state_t;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic       sampling;
        logic       convStart;
        logic [1:0] convChan;
        logic [4:0] chZeroPos;
        logic       chZeroNegIn1;
        logic       ch123PosHigh;
        logic       ch123NegGround;
        logic       rcClockSel;
        logic [2:0] referenceConfig;
    } analog_ctl_t;

    typedef struct packed {
        logic [15:0] con2;
        logic [15:0] con3;
        logic [15:0] chs123;
        logic [15:0] chs0;
        logic [15:0] runCtl;
        logic [5:0]  scanSel;
        seq_state_t  seq;
        logic [7:0]  divCnt;
        logic [4:0]  smpCnt;
        logic [1:0]  chanIdx;
        logic [3:0]  opCnt;
        logic [3:0]  wrPtr;
        logic        half;
        logic        useB;
        logic [2:0]  scanIdx;
        logic        bufWe;
        logic [3:0]  bufAddr;
        logic [9:0]  bufData;
        logic        intPulse;
        analog_ctl_t ana;
        apb_rsp_t    rsp;
    } seq_regs_t;
endpackage : sar_adc_sequence_control_pkg

// ===== sim/sar_adc_sequence_control_chk.sv
// concurrent checks on the ports of the converter sequence control
`timescale 1ns/1ps
module sar_adc_sequence_control_chk (
    input wire logic                                   ref_clk,
    input wire logic                                   rst_b,
    input wire sar_adc_sequence_control_pkg::apb_req_t apbReq,
    input wire logic                                   pready,
    input wire logic [31:0]                            prdata,
    input wire logic                                   convDone,
    input wire sar_adc_sequence_control_pkg::analog_ctl_t analogCtl,
    input wire logic                                   adcIntPulse
);
    import sar_adc_sequence_control_pkg::*;
    // ---------------------------------------------------------------
    // bus side
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic rdAccess;
    assign rdAccess = apbReq.psel && apbReq.penable && !apbReq.pwrite;
    ready_in_access_a: assert property (apbReq.psel && apbReq.penable |-> pready)
        else $error("access phase without ready");
    upper_read_zero_a: assert property (rdAccess |-> prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    con_two_gaps_a: assert property (rdAccess && apbReq.paddr == 8'h00 |-> prdata[12:11] == 2'h0 && !prdata[6])
        else $error("control two gap bits set");
    con_three_gaps_a: assert property (rdAccess && apbReq.paddr == 8'h04 |-> prdata[14:13] == 2'h0)
        else $error("control three gap bits set");
    sel_gaps_a: assert property (rdAccess && apbReq.paddr == 8'h08 |-> prdata[15:11] == 5'h00 && prdata[7:3] == 5'h00)
        else $error("channel 1-3 select gap bits set");
    // ---------------------------------------------------------------
    // conversion side
    // ---------------------------------------------------------------
    conv_ends_sample_a: assert property ($fell(analogCtl.sampling) |-> analogCtl.convStart)
        else $error("sampling ended without conversion start");
    conv_pulse_a: assert property (analogCtl.convStart |=> !analogCtl.convStart)
        else $error("conversion start longer than one cycle");
    next_chan_a: assert property (analogCtl.convStart && analogCtl.convChan != 2'h0 |-> $past(convDone, 2))
        else $error("next channel started without prior done");
    int_pulse_a: assert property (adcIntPulse |=> !adcIntPulse)
        else $error("interrupt longer than one cycle");
    int_after_store_a: assert property (adcIntPulse |-> $past(convDone, 2))
        else $error("interrupt not tied to a finished conversion");
endmodule : sar_adc_sequence_control_chk

// ===== sim/sar_core_model.sv
// behavioural model of the sar core and its rc clock
`timescale 1ns/1ps
module sar_core_model #(
    parameter int LAT = 12
) (
    input  wire logic       ref_clk,
    input  wire logic       convStart,
    input  wire logic [1:0] convChan,
    output logic            rcTick,
    output logic            convDone,
    output logic [9:0]      convData
);
    int         cnt = 0;
    int         rcCnt = 0;
    logic [7:0] convNum = 8'h00;
    logic [1:0] chan = 2'h0;
    initial begin
        rcTick = 1'b0;
        convDone = 1'b0;
        convData = 10'h155;
    end
    // ---------------------------------------------------------------
    // rc runs free; result word carries its order number and channel
    // ---------------------------------------------------------------
    always @(posedge ref_clk) begin
        rcCnt <= (rcCnt == 4) ? 0 : rcCnt + 1;
        rcTick <= (rcCnt == 4);
        convDone <= 1'b0;
        if (convDone) begin
            convData <= ~convData;  // no stale value once done has passed
        end
        if (convStart) begin
            cnt <= LAT;
            chan <= convChan;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            convDone <= 1'b1;
            convData <= {convNum, chan};
            convNum <= convNum + 8'h01;
        end
    end
endmodule : sar_core_model

// ===== sim/test_sar_adc_sequence_control.sv
// register and conversion sequence tests of the converter sequence control
`timescale 1ns/1ps
module test_sar_adc_sequence_control;
    import sar_adc_sequence_control_pkg::*;
    logic        ref_clk;
    logic        rst_b;
    apb_req_t    apbReq;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        rcTick;
    logic        extTrigger;
    logic        convDone;
    logic [9:0]  convData;
    analog_ctl_t analogCtl;
    analog_ctl_t selSnap;
    logic        adcIntPulse;
    logic        bufferHalf;
    logic [31:0] rd;
    logic        err;
    logic [15:0] masks [4] = '{16'he73f, 16'h9fff, 16'h0707, 16'h9f9f};
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          smpLen = 0;
    int          lastSmp = 0;
    int          intCount = 0;
    int          doneCnt = 0;
    int          doneAtInt = 0;

    sar_adc_sequence_control uut (.ref_clk(ref_clk), .rst_b(rst_b), .apbReq(apbReq), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .rcTick(rcTick), .extTrigger(extTrigger), .convDone(convDone),
        .convData(convData), .analogCtl(analogCtl), .adcIntPulse(adcIntPulse), .bufferHalf(bufferHalf));
    sar_core_model core (.ref_clk(ref_clk), .convStart(analogCtl.convStart), .convChan(analogCtl.convChan),
        .rcTick(rcTick), .convDone(convDone), .convData(convData));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ---------------------------------------------------------------
    // monitor: sample length, selects in use, conversions per interrupt
    // ---------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (analogCtl.sampling === 1'b1) begin
            smpLen <= smpLen + 1;
            selSnap <= analogCtl;
        end
        if (analogCtl.convStart === 1'b1 && analogCtl.convChan === 2'h0) begin
            lastSmp <= smpLen;
            smpLen <= 0;
        end
        if (convDone === 1'b1) doneCnt <= doneCnt + 1;
        if (adcIntPulse === 1'b1) begin
            intCount <= intCount + 1;
            doneAtInt <= doneCnt;
            doneCnt <= 0;
        end
    end
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic end_sim();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    // request held until ready is seen high at an edge
    task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                            output logic [31:0] rdata, output logic rerr);
        int n;
        @(posedge ref_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        if (n >= 20) begin
            n_mismatch++;
            end_sim();
        end
    endtask : apb_xfer
    // one manual-start sequence, auto-ended by the internal counter
    task automatic run_op();
        int n;
        int start;
        start = intCount;
        apb_xfer(1'b1, 8'h10, 32'h0000_00e3, rd, err);
        n = 0;
        while (intCount == start && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 3000) begin
            n_mismatch++;
            end_sim();
        end
    endtask : run_op
    task automatic check_words(input int base, input int first);
        for (int i = 0; i < 4; i++) begin
            apb_xfer(1'b0, 8'h40 + 8'(4 * (base + i)), 32'h0, rd, err);
            check_val(rd, {22'h0, 8'(first + i), 2'(i)});
        end
    endtask : check_words
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        extTrigger = 1'b0;
        apbReq = '0;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb_xfer(1'b1, 8'(4 * i), 32'h0000_ffff, rd, err);
            apb_xfer(1'b0, 8'(4 * i), 32'h0, rd, err);
            check_val(rd, {16'h0000, masks[i]});
        end
        apb_xfer(1'b0, 8'h18, 32'h0, rd, err);
        check_val(rd, 32'h0);
        check_val({31'h0, err}, 32'h1);
        $display("test registers done");
        // ch0 A: input 5 vs ground, B: input 3 vs input 1; ch1-3 A high set, B low set
        apb_xfer(1'b1, 8'h0c, 32'h0000_8305, rd, err);
        apb_xfer(1'b1, 8'h08, 32'h0000_0001, rd, err);
        apb_xfer(1'b1, 8'h04, 32'h0000_0201, rd, err);
        apb_xfer(1'b1, 8'h00, 32'h0000_a20f, rd, err);
        run_op();
        check_words(0, 0);
        check_val(32'(doneAtInt), 32'h4);
        check_val({31'h0, bufferHalf}, 32'h1);
        apb_xfer(1'b0, 8'h00, 32'h0, rd, err);
        check_val(rd, 32'h0000_a28f);
        check_val({20'h0, selSnap.chZeroPos, selSnap.chZeroNegIn1, selSnap.ch123PosHigh, selSnap.ch123NegGround,
                   selSnap.rcClockSel, selSnap.referenceConfig}, {20'h0, 5'h05, 4'h6, 3'h5});
        check_val(32'(lastSmp >= 4 && lastSmp <= 7), 32'h1);
        $display("test first sequence done");
        apb_xfer(1'b1, 8'h04, 32'h0000_8201, rd, err);
        run_op();
        check_words(8, 4);
        check_val({31'h0, bufferHalf}, 32'h0);
        check_val({20'h0, selSnap.chZeroPos, selSnap.chZeroNegIn1, selSnap.ch123PosHigh, selSnap.ch123NegGround,
                   selSnap.rcClockSel, selSnap.referenceConfig}, {20'h0, 5'h03, 4'hb, 3'h5});
        check_val(32'(lastSmp >= 11 && lastSmp <= 15), 32'h1);
        $display("test second sequence done");
        // scan inputs 2 and 4 on ch0 only, interrupt per conversion, no split
        apb_xfer(1'b1, 8'h14, 32'h0000_0014, rd, err);
        apb_xfer(1'b1, 8'h00, 32'h0000_a400, rd, err);
        for (int i = 0; i < 2; i++) begin
            run_op();
            check_val(32'(selSnap.chZeroPos), 32'(2 + 2 * i));
            check_val(32'(doneAtInt), 32'h1);
            apb_xfer(1'b0, 8'h40, 32'h0, rd, err);
            check_val(rd, {22'h0, 8'(8 + i), 2'h0});
        end
        $display("test scan sequence done");
        end_sim();
    end
endmodule : test_sar_adc_sequence_control

bind sar_adc_sequence_control sar_adc_sequence_control_chk chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .apbReq(apbReq), .pready(pready), .prdata(prdata), .convDone(convDone), .analogCtl(analogCtl),
    .adcIntPulse(adcIntPulse));
